// >>> logic/sdm_mode_ctrl.sv
/*
 * Mode-control register bank, attenuators with stepped ramp and soft mute,
 * channel disable, phase inversion and zero flags of a stereo converter.
 * Assumes the serial audio receiver delivers samples on ref_clk, valid at each
 * rising edge of the word clock, and that the host stops the control clock
 * while the latch strobe is high.
 */
// Notes on behaviour
// - Attenuation 0 to -63 dB, half-dB steps, mute.
// - Step one code every eight sample periods.
// - Gain equals half of code minus 255 dB.
// - Codes 0 through 128 mute the channel.
// - Independent left/right codes, reset to unity.
// - Soft mute ramps down to full mute.
// - Clearing soft mute ramps back to programmed level.
// - Oversample bit selects 64x or 128x.
// - Channel off forces midscale output.
// - De-emphasis enable bit, off after reset.
// - De-emphasis rate field selects filter rate.
// - Format field selects serial audio format.
// - Roll-off bit selects sharp or slow.
// - Phase bit inverts both outputs.
// - Polarity bit sets zero flag active level.
// - Combine bit merges zero flags onto one pin.
// - Zero detect after 1024 zero samples.
// - Sixteen-bit word: zero, index, data.
// - Word latched on strobe rising edge.
module sdm_mode_ctrl
    import sdm_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    // Serial control port
    input  wire logic                       ctrl_clock,
    input  wire logic                       latch_strobe,
    input  wire logic                       ctrl_serial_in,
    // Audio side
    input  wire logic                       word_clock,
    input  wire logic signed [SAMPLE_W-1:0] left_sample,
    input  wire logic signed [SAMPLE_W-1:0] right_sample,
    output      logic signed [SAMPLE_W-1:0] left_output,
    output      logic signed [SAMPLE_W-1:0] right_output,
    output      sdm_filter_cfg_t            filter_cfg,
    // Zero flags
    output      logic                       right_zero_flag,
    output      logic                       left_zero_flag
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [CTRL_WORD_W-1:0] shift;
    } sdm_link_state_t;

    typedef struct packed {
        sdm_cfg_t                        cfg;
        logic [2:0]                      ml_sync;
        logic                            ml_filt;
        logic [2:0]                      wc_sync;
        logic                            wc_filt;
        logic [1:0][7:0]                 level;
        logic [2:0]                      step_cnt;
        logic [1:0][10:0]                zero_cnt;
        logic [1:0][SAMPLE_W-1:0]        out;
        logic                            zflag_pin11;
        logic                            zflag_pin12;
    } sdm_state_t;

    sdm_link_state_t lk_r;
    sdm_link_state_t lk_nxt;
    sdm_state_t      st_r;
    sdm_state_t      st_nxt;
    logic            strobe_rise;
    logic            sample_tick;
    logic            step_go;
    logic [1:0][7:0] target;
    logic [1:0]      zero_det;
    logic [CTRL_WORD_W-1:0] word;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // ==========================================================
    // Functions
    // Entry zero is exactly one in Q15, so code 255 leaves samples unchanged.
    function automatic logic [15:0] gain_q15(input logic [3:0] ix);
        logic [15:0] g;
        unique case (ix)
            4'h0:    g = 16'h8000;
            4'h1:    g = 16'h78D6;
            4'h2:    g = 16'h7215;
            4'h3:    g = 16'h6BB3;
            4'h4:    g = 16'h65AD;
            4'h5:    g = 16'h5FFD;
            4'h6:    g = 16'h5A9E;
            4'h7:    g = 16'h558C;
            4'h8:    g = 16'h50C3;
            4'h9:    g = 16'h4C3F;
            4'hA:    g = 16'h47FB;
            4'hB:    g = 16'h43F4;
            default: g = 16'h7FFF;
        endcase
        return g;
    endfunction

    // Each 12 codes halve the gain; the remainder indexes a 0.5 dB mantissa.
    function automatic logic signed [SAMPLE_W-1:0] scale(
        input logic signed [SAMPLE_W-1:0] s,
        input logic [7:0]                 lvl
    );
        logic [7:0]                 att;
        logic [3:0]                 sh;
        logic [3:0]                 ix;
        logic signed [SAMPLE_W+16:0] p;
        att = ATT_UNITY - lvl;
        sh  = 4'(att / {4'h0, GAIN_STEPS});
        ix  = 4'(att % {4'h0, GAIN_STEPS});
        p   = s * $signed({1'b0, gain_q15(ix)});
        p   = p >>> 15;
        p   = p >>> sh;
        if (lvl <= MUTE_LEVEL) begin
            return '0;
        end
        return p[SAMPLE_W-1:0];
    endfunction

    // Soft mute or any code at or below the mute code aims at full mute.
    function automatic logic [7:0] ramp_target(input logic [7:0] code, input logic mute);
        if (mute || code <= MUTE_LEVEL) begin
            return MUTE_LEVEL;
        end
        return code;
    endfunction

    // ==========================================================
    // Control-clock domain: shift in the word while the strobe is low.
    always_comb begin
        lk_nxt = lk_r;
        if (!latch_strobe) begin
            lk_nxt.shift = {lk_r.shift[CTRL_WORD_W-2:0], ctrl_serial_in};
        end
    end

    always_ff @(posedge ctrl_clock) begin
        lk_r <= lk_nxt;
    end

    // The word is static while the strobe is high, since the host stops the
    // control clock; the filtered strobe edge below qualifies it.
    assign word = lk_r.shift;

    // ==========================================================
    // Register-clock domain.
    assign strobe_rise = (st_r.ml_sync[1] == st_r.ml_sync[2]) && st_r.ml_sync[2]
                         && !st_r.ml_filt;
    assign sample_tick = (st_r.wc_sync[1] == st_r.wc_sync[2]) && st_r.wc_sync[2]
                         && !st_r.wc_filt;
    assign step_go     = sample_tick && (st_r.step_cnt == STEP_LAST);
    assign target[0]   = ramp_target(st_r.cfg.left_atten, st_r.cfg.soft_mute_bit[0]);
    assign target[1]   = ramp_target(st_r.cfg.right_atten, st_r.cfg.soft_mute_bit[1]);
    assign zero_det[0] = (st_r.zero_cnt[0] == ZERO_RUN);
    assign zero_det[1] = (st_r.zero_cnt[1] == ZERO_RUN);

    always_comb begin
        logic signed [SAMPLE_W-1:0] smp;
        logic signed [SAMPLE_W-1:0] scaled;
        smp    = '0;
        scaled = '0;
        st_nxt = st_r;

        // Pin synchronisers; a change counts once stages two and three agree.
        st_nxt.ml_sync = {st_r.ml_sync[1:0], latch_strobe};
        st_nxt.wc_sync = {st_r.wc_sync[1:0], word_clock};
        if (st_r.ml_sync[1] == st_r.ml_sync[2]) begin
            st_nxt.ml_filt = st_r.ml_sync[2];
        end
        if (st_r.wc_sync[1] == st_r.wc_sync[2]) begin
            st_nxt.wc_filt = st_r.wc_sync[2];
        end

        // Register write; a word with its top bit set is dropped.
        if (strobe_rise && !word[POS_WORD_TOP]) begin
            unique case (word[14:8])
                IDX_LEFT_ATT:   st_nxt.cfg.left_atten  = word[7:0];
                IDX_RIGHT_ATT:  st_nxt.cfg.right_atten = word[7:0];
                IDX_MUTE_OVER: begin
                    st_nxt.cfg.soft_mute_bit  = word[1:0];
                    st_nxt.cfg.oversample_128 = word[POS_OVERSAMPLE];
                end
                IDX_CHAN_DEEMP: begin
                    st_nxt.cfg.channel_off   = word[1:0];
                    st_nxt.cfg.deemph_enable = word[POS_DEEMPH_EN];
                    st_nxt.cfg.deemph_rate   = word[POS_DEEMPH_LO+:2];
                end
                IDX_FMT_ROLL: begin
                    st_nxt.cfg.audio_format_sel = word[2:0];
                    st_nxt.cfg.rolloff_select   = word[POS_ROLLOFF];
                end
                IDX_ZFLAG_PH: begin
                    st_nxt.cfg.phase_invert       = word[POS_PHASE_INV];
                    st_nxt.cfg.zero_flag_polarity = word[POS_ZFLAG_POL];
                    st_nxt.cfg.zero_flag_combine  = word[POS_ZFLAG_COMB];
                end
                default: ;
            endcase
        end

        if (sample_tick) begin
            st_nxt.step_cnt = st_r.step_cnt + 3'h1;
        end

        for (int c = 0; c < 2; c++) begin
            // One code toward the newest target per step slot.
            if (step_go && st_r.level[c] < target[c]) begin
                st_nxt.level[c] = st_r.level[c] + 8'h01;
            end else if (step_go && st_r.level[c] > target[c]) begin
                st_nxt.level[c] = st_r.level[c] - 8'h01;
            end

            smp = (c == 0) ? left_sample : right_sample;
            if (sample_tick) begin
                if (smp != '0) begin
                    st_nxt.zero_cnt[c] = '0;
                end else if (st_r.zero_cnt[c] != ZERO_RUN) begin
                    st_nxt.zero_cnt[c] = st_r.zero_cnt[c] + 11'h001;
                end
                scaled = scale(smp, st_r.level[c]);
                if (st_r.cfg.channel_off[c]) begin
                    st_nxt.out[c] = '0;
                end else if (st_r.cfg.phase_invert) begin
                    st_nxt.out[c] = -scaled;
                end else begin
                    st_nxt.out[c] = scaled;
                end
            end
        end

        // Pin 11 carries the right or common flag; pin 12 the left or nothing.
        st_nxt.zflag_pin11 = st_r.cfg.zero_flag_polarity ^
            (st_r.cfg.zero_flag_combine ? (zero_det[0] & zero_det[1])
                                        : zero_det[1]);
        st_nxt.zflag_pin12 = st_r.cfg.zero_flag_polarity ^
            (st_r.cfg.zero_flag_combine ? 1'b0 : zero_det[0]);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r                        <= '0;
            st_r.cfg.left_atten         <= ATT_UNITY;
            st_r.cfg.right_atten        <= ATT_UNITY;
            st_r.cfg.audio_format_sel   <= FMT_RESET;
            st_r.cfg.deemph_rate        <= RATE_RESET;
            st_r.ml_sync                <= 3'h7;
            st_r.ml_filt                <= 1'b1;
            st_r.level                  <= {ATT_UNITY, ATT_UNITY};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign left_output                 = st_r.out[0];
    assign right_output                = st_r.out[1];
    assign right_zero_flag             = st_r.zflag_pin11;
    assign left_zero_flag              = st_r.zflag_pin12;
    assign filter_cfg.oversample_128   = st_r.cfg.oversample_128;
    assign filter_cfg.deemph_enable    = st_r.cfg.deemph_enable;
    assign filter_cfg.deemph_rate      = st_r.cfg.deemph_rate;
    assign filter_cfg.audio_format_sel = st_r.cfg.audio_format_sel;
    assign filter_cfg.rolloff_select   = st_r.cfg.rolloff_select;

    // ==========================================================
    // Checks
    sequence seq_left_write;
        strobe_rise && !word[POS_WORD_TOP] && (word[14:8] == IDX_LEFT_ATT);
    endsequence

    sequence seq_mute_write;
        strobe_rise && !word[POS_WORD_TOP] && (word[14:8] == IDX_MUTE_OVER);
    endsequence

    left_code_latch_a: assert property (seq_left_write |=>
        st_r.cfg.left_atten == $past(word[7:0]))
        else $error("left attenuation not latched from control word");

    mute_bits_latch_a: assert property (seq_mute_write |=>
        st_r.cfg.soft_mute_bit == $past(word[1:0]))
        else $error("soft mute bits not latched from control word");

    step_slot_a: assert property ((st_r.level[0] != $past(st_r.level[0])) |->
        $past(step_go))
        else $error("left level moved outside a step slot");

    step_size_a: assert property ($past(step_go) |->
        (st_r.level[1] - $past(st_r.level[1]) inside {8'h00, 8'h01, 8'hFF}))
        else $error("right level moved more than one code");

    step_toward_a: assert property ((step_go && st_r.level[0] != target[0]) |=>
        (st_r.level[0] != $past(st_r.level[0])))
        else $error("left level did not step toward target");

    mute_target_a: assert property ((st_r.cfg.left_atten <= MUTE_LEVEL) |->
        target[0] == MUTE_LEVEL)
        else $error("low code did not aim at full mute");

    unmute_target_a: assert property ((!st_r.cfg.soft_mute_bit[1] &&
        st_r.cfg.right_atten > MUTE_LEVEL) |-> target[1] == st_r.cfg.right_atten)
        else $error("right target differs from programmed code");

    channel_off_a: assert property ((sample_tick && st_r.cfg.channel_off[0]) |=>
        left_output == '0)
        else $error("disabled left channel not at midscale");

    muted_output_a: assert property ((sample_tick && st_r.level[1] == MUTE_LEVEL)
        |=> right_output == '0)
        else $error("muted right channel produced data");

    zero_run_a: assert property ((sample_tick && left_sample != '0) |=>
        !zero_det[0] [*2])
        else $error("left zero detect without a zero run");

    flag_map_a: assert property ((!st_r.cfg.zero_flag_combine &&
        !st_r.cfg.zero_flag_polarity && zero_det[0]) |=> left_zero_flag)
        else $error("left zero flag not raised");

    flag_polarity_a: assert property ((st_r.cfg.zero_flag_polarity &&
        st_r.cfg.zero_flag_combine) |=> left_zero_flag)
        else $error("unassigned flag pin not at inactive level");

    right_flag_a: assert property ((!st_r.cfg.zero_flag_combine &&
        !st_r.cfg.zero_flag_polarity && zero_det[1]) |=> right_zero_flag)
        else $error("right zero flag not raised");

    zero_set_a: assert property ((sample_tick && right_sample == '0 &&
        st_r.zero_cnt[1] == ZERO_RUN - 11'h001) |=> zero_det[1])
        else $error("right zero detect missing after a full zero run");

    right_slot_a: assert property ((st_r.level[1] != $past(st_r.level[1])) |->
        $past(step_go))
        else $error("right level moved outside a step slot");

    unity_gain_a: assert property ((sample_tick && st_r.level[0] == ATT_UNITY &&
        !st_r.cfg.channel_off[0] && !st_r.cfg.phase_invert) |=>
        left_output == $past(left_sample))
        else $error("left channel not unity at full-scale code");

    phase_flip_a: assert property ((sample_tick && st_r.level[1] == ATT_UNITY &&
        !st_r.cfg.channel_off[1] && st_r.cfg.phase_invert) |=>
        right_output == -$past(right_sample))
        else $error("right channel not inverted");

    dropped_word_a: assert property ((strobe_rise && word[POS_WORD_TOP]) |=>
        $stable(st_r.cfg))
        else $error("word with top bit set changed a register");

    // A flag register write carries both flag controls and the phase bit.
    sequence seq_zflag_write;
        strobe_rise && !word[POS_WORD_TOP] && (word[14:8] == IDX_ZFLAG_PH);
    endsequence

    zflag_latch_a: assert property (seq_zflag_write |=>
        st_r.cfg.zero_flag_polarity == $past(word[POS_ZFLAG_POL]) &&
        st_r.cfg.zero_flag_combine == $past(word[POS_ZFLAG_COMB]) &&
        st_r.cfg.phase_invert == $past(word[POS_PHASE_INV]))
        else $error("flag register not latched from control word");

endmodule

// >>> logic/sdm_pkg.sv
/*
 * Constants and carrier types for the stereo converter mode-control block.
 * Assumes a 200 MHz register clock and a 7-bit register index on the control port.
 */
package sdm_pkg;

    // ==========================================================
    // Register indices
    localparam logic [6:0] IDX_LEFT_ATT   = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATT  = 7'h11;
    localparam logic [6:0] IDX_MUTE_OVER  = 7'h12;
    localparam logic [6:0] IDX_CHAN_DEEMP = 7'h13;
    localparam logic [6:0] IDX_FMT_ROLL   = 7'h14;
    localparam logic [6:0] IDX_ZFLAG_PH   = 7'h16;

    // ==========================================================
    // Field positions
    localparam int POS_OVERSAMPLE  = 6;
    localparam int POS_DEEMPH_EN   = 4;
    localparam int POS_DEEMPH_LO   = 5;
    localparam int POS_ROLLOFF     = 5;
    localparam int POS_PHASE_INV   = 0;
    localparam int POS_ZFLAG_POL   = 1;
    localparam int POS_ZFLAG_COMB  = 2;
    localparam int CTRL_WORD_W     = 16;
    localparam int POS_WORD_TOP    = 15;

    // ==========================================================
    // Reset values and levels
    localparam logic [7:0] ATT_UNITY    = 8'hFF;
    localparam logic [7:0] MUTE_LEVEL   = 8'h80;
    localparam logic [2:0] FMT_RESET    = 3'h5;
    localparam logic [1:0] RATE_RESET   = 2'h0;
    localparam logic [3:0] GAIN_STEPS   = 4'hC;

    // ==========================================================
    // Counts in sample periods
    localparam logic [2:0]  STEP_LAST   = 3'h7;
    localparam logic [10:0] ZERO_RUN    = 11'h400;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] left_atten;
        logic [7:0] right_atten;
        logic [1:0] soft_mute_bit;
        logic       oversample_128;
        logic [1:0] channel_off;
        logic       deemph_enable;
        logic [1:0] deemph_rate;
        logic [2:0] audio_format_sel;
        logic       rolloff_select;
        logic       phase_invert;
        logic       zero_flag_polarity;
        logic       zero_flag_combine;
    } sdm_cfg_t;

    typedef struct packed {
        logic       oversample_128;
        logic       deemph_enable;
        logic [1:0] deemph_rate;
        logic [2:0] audio_format_sel;
        logic       rolloff_select;
    } sdm_filter_cfg_t;

endpackage

// >>> tb/sdm_host_model.sv
/*
 * Host model for the serial control port: sends 16-bit control words.
 * Assumes the bench calls send() and that the device filters the strobe on a 200 MHz clock.
 */
module sdm_host_model (
    // Serial control port
    output logic ctrl_clock,
    output logic latch_strobe,
    output logic ctrl_serial_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Idle state
    initial begin
        ctrl_clock     = 1'b0;
        latch_strobe   = 1'b1;
        ctrl_serial_in = 1'b1;
    end

    // ==========================================================
    // Frame
    // The control clock runs at 32 ns only inside a frame and stands still between frames.
    task automatic send(input logic [15:0] word);
        #3.7;
        latch_strobe = 1'b0;
        #16;
        for (int i = 15; i >= 0; i--) begin
            ctrl_serial_in = word[i];
            #16;
            ctrl_clock = 1'b1;
            #16;
            ctrl_clock = 1'b0;
        end
        #16;
        ctrl_serial_in = ~word[0];
        latch_strobe   = 1'b1;
        #40;
    endtask
endmodule

// >>> tb/tb_top.sv
/*
 * Self-checking bench for the mode-control block: registers, ramps and zero flags.
 * Assumes the host model drives the control port and the bench owns samples and word clock.
 */
`define SDM_CHECK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("MISMATCH at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
end

module tb_top
    import sdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic signed [23:0] L_VAL = 24'sh400000;
    localparam logic signed [23:0] R_VAL = 24'sh200000;

    logic                     ref_clk;
    logic                     reset;
    logic                     word_clock;
    logic                     ctrl_clock;
    logic                     latch_strobe;
    logic                     ctrl_serial_in;
    logic signed [23:0]       left_sample;
    logic signed [23:0]       right_sample;
    logic signed [23:0]       left_output;
    logic signed [23:0]       right_output;
    sdm_filter_cfg_t          filter_cfg;
    logic                     right_zero_flag;
    logic                     left_zero_flag;
    int                       err_count;
    int                       tests_run;

    // ==========================================================
    // Clocks and instances
    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;
    initial word_clock = 1'b0;
    always #40 word_clock = ~word_clock;

    sdm_host_model host (
        .ctrl_clock     (ctrl_clock),
        .latch_strobe   (latch_strobe),
        .ctrl_serial_in (ctrl_serial_in)
    );

    sdm_mode_ctrl #(.SAMPLE_W(24)) DUT (
        .ref_clk         (ref_clk),
        .reset           (reset),
        .ctrl_clock      (ctrl_clock),
        .latch_strobe    (latch_strobe),
        .ctrl_serial_in  (ctrl_serial_in),
        .word_clock      (word_clock),
        .left_sample     (left_sample),
        .right_sample    (right_sample),
        .left_output     (left_output),
        .right_output    (right_output),
        .filter_cfg      (filter_cfg),
        .right_zero_flag (right_zero_flag),
        .left_zero_flag  (left_zero_flag)
    );

    // ==========================================================
    // Helpers
    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] data);
        host.send({1'b0, idx, data});
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge word_clock);
    endtask

    // Counts sample periods until the chosen output settles on the target.
    task automatic ramp(input logic sel_r, input logic signed [23:0] target, output int n);
        n = 0;
        while (n < 1100 && (sel_r ? right_output : left_output) !== target) begin
            @(negedge word_clock);
            n++;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        tick(2);
        `SDM_CHECK(filter_cfg, sdm_filter_cfg_t'({4'h0, FMT_RESET, 1'b0}))
        `SDM_CHECK(left_output, L_VAL)
        `SDM_CHECK(right_output, R_VAL)
        `SDM_CHECK({left_zero_flag, right_zero_flag}, 2'h0)
    endtask

    task automatic t_cfg();
        logic [2:0] f;
        logic [1:0] r;
        for (int i = 0; i < 6; i++) begin
            f = 3'(i);
            r = 2'(i % 3);
            wr(IDX_FMT_ROLL, {2'h0, f[0], 2'h0, f});
            wr(IDX_CHAN_DEEMP, {1'h0, r, f[1], 4'h0});
            wr(IDX_MUTE_OVER, {1'h0, f[2], 6'h00});
            `SDM_CHECK(filter_cfg, sdm_filter_cfg_t'({f[2], f[1], r, f, f[0]}))
        end
        wr(7'h15, 8'h00);
        host.send({1'b1, IDX_FMT_ROLL, 8'h00});
        repeat (2) @(negedge ref_clk);
        `SDM_CHECK(filter_cfg, sdm_filter_cfg_t'(8'hAB))
        wr(IDX_MUTE_OVER, 8'h00);
        wr(IDX_CHAN_DEEMP, 8'h00);
        wr(IDX_FMT_ROLL, 8'h05);
    endtask

    task automatic t_phase();
        wr(IDX_ZFLAG_PH, 8'h01);
        tick(2);
        `SDM_CHECK(left_output, -L_VAL)
        `SDM_CHECK(right_output, -R_VAL)
        wr(IDX_CHAN_DEEMP, 8'h01);
        tick(2);
        `SDM_CHECK(left_output, 24'sh000000)
        `SDM_CHECK(right_output, -R_VAL)
        wr(IDX_CHAN_DEEMP, 8'h00);
        wr(IDX_ZFLAG_PH, 8'h00);
        tick(2);
        `SDM_CHECK(left_output, L_VAL)
    endtask

    task automatic t_ramps();
        int n;
        wr(IDX_LEFT_ATT, 8'h80);
        ramp(1'b0, 24'sh000000, n);
        `SDM_CHECK(n >= 1000 && n <= 1030, 1'b1)
        `SDM_CHECK(right_output, R_VAL)
        wr(IDX_MUTE_OVER, 8'h02);
        ramp(1'b1, 24'sh000000, n);
        `SDM_CHECK(n >= 1000 && n <= 1030, 1'b1)
        wr(IDX_MUTE_OVER, 8'h00);
        ramp(1'b1, R_VAL, n);
        `SDM_CHECK(n >= 1000 && n <= 1030, 1'b1)
    endtask

    task automatic t_zero();
        int n;
        @(negedge word_clock);
        @(negedge ref_clk);
        left_sample = 24'sh000000;
        tick(16);
        @(negedge ref_clk);
        right_sample = 24'sh000000;
        n = 16;
        while (n < 1100 && left_zero_flag !== 1'b1) begin
            @(negedge word_clock);
            n++;
        end
        `SDM_CHECK(n >= 1020 && n <= 1030, 1'b1)
        `SDM_CHECK(right_zero_flag, 1'b0)
        tick(20);
        `SDM_CHECK(right_zero_flag, 1'b1)
        wr(IDX_ZFLAG_PH, 8'h04);
        tick(1);
        `SDM_CHECK({left_zero_flag, right_zero_flag}, 2'b01)
        wr(IDX_ZFLAG_PH, 8'h06);
        tick(1);
        `SDM_CHECK({left_zero_flag, right_zero_flag}, 2'b10)
        wr(IDX_ZFLAG_PH, 8'h02);
        tick(1);
        `SDM_CHECK({left_zero_flag, right_zero_flag}, 2'b00)
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        err_count    = 0;
        tests_run    = 0;
        reset        = 1'b1;
        left_sample  = L_VAL;
        right_sample = R_VAL;
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_cfg();
        t_phase();
        t_ramps();
        t_zero();
        give_verdict();
    end

    initial begin
        #450000;
        err_count++;
        give_verdict();
    end
endmodule
